// ===== logic/fsp_sequencer.sv
// Purpose: flash self-programming sequencer with AXI4-Lite control
// Assumes: core strobes STORE_INSTR with pointer and data pair valid
// Notes:   halts the core during erase and page programming
// Behaviour
// - store instruction accepted from any flash location, no boot region
// - each page-load store puts exactly one word into the buffer
// - buffer words may be loaded in any order
// - erase only after control 00000011 and store within four cycles
// - erase uses page index only, ignores other pointer bits and data
// - core halted for the whole erase
// - load after control 00000001 and store within four cycles
// - load location comes from the word-in-page pointer field
// - buffer cleared after page write and on section read enable write
// - buffer cleared on reset
// - data EEPROM write discards loaded buffer contents
// - write after control 00000101 and store within four cycles, halted
// - enable bit self-clears on store or timeout, held through erase/write
// - only five listed control combinations arm, others ignored
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module fsp_sequencer
#(
	parameter int ERASE_CYCLES = fsp_pkg::ERASE_CYC,
	parameter int WRITE_CYCLES = fsp_pkg::WRITE_CYC
)
(
	input  wire logic                          REF_CLK,
	input  wire logic                          ARST_N,
	input  wire logic [7:0]                    S_AXI_AWADDR,
	input  wire logic                          S_AXI_AWVALID,
	output var  logic                          S_AXI_AWREADY,
	input  wire logic [31:0]                   S_AXI_WDATA,
	input  wire logic [3:0]                    S_AXI_WSTRB,
	input  wire logic                          S_AXI_WVALID,
	output var  logic                          S_AXI_WREADY,
	output var  logic [1:0]                    S_AXI_BRESP,
	output var  logic                          S_AXI_BVALID,
	input  wire logic                          S_AXI_BREADY,
	input  wire logic [7:0]                    S_AXI_ARADDR,
	input  wire logic                          S_AXI_ARVALID,
	output var  logic                          S_AXI_ARREADY,
	output var  logic [31:0]                   S_AXI_RDATA,
	output var  logic [1:0]                    S_AXI_RRESP,
	output var  logic                          S_AXI_RVALID,
	input  wire logic                          S_AXI_RREADY,
	input  wire logic                          STORE_INSTR,
	input  wire logic [fsp_pkg::PTR_BITS-1:0]  FLASH_PTR,
	input  wire logic [fsp_pkg::WORD_BITS-1:0] DATA_PAIR,
	input  wire logic                          EEPROM_WRITE,
	output var  logic                          CPU_HALT,
	output var  logic                          FLASH_ERASE,
	output var  logic                          FLASH_PROG,
	output var  logic [fsp_pkg::PAGE_BITS-1:0] FLASH_PAGE,
	output var  logic [fsp_pkg::WIDX_BITS-1:0] FLASH_WIDX,
	output var  logic [fsp_pkg::WORD_BITS-1:0] FLASH_WDATA
);
	typedef enum logic [2:0] {
		FSP_IDLE,
		FSP_ARMED,
		FSP_ERASE,
		FSP_STREAM,
		FSP_PROGRAM
	} fsp_state_t;

	localparam int PAGE_W = fsp_pkg::PAGE_BITS;
	localparam int WIDX_W = fsp_pkg::WIDX_BITS;

	fsp_state_t                 state_ff;
	fsp_state_t                 nxt_state;
	logic [4:0]                 ctrl_ff;
	logic [2:0]                 win_ff;
	logic [19:0]                busy_cnt_ff;
	logic [WIDX_W-1:0]          idx_ff;
	logic                       stream_vld_ff;
	logic [WIDX_W-1:0]          stream_idx_ff;
	logic [PAGE_W-1:0]          page_ff;
	logic [fsp_pkg::PAGE_WORDS-1:0] valid_ff;
	logic [fsp_pkg::WORD_BITS-1:0]  mem_rdata;

	logic                       wr_fire;
	logic                       wr_ctrl;
	logic                       wr_hit;
	logic [4:0]                 wr_cmd;
	logic                       cmd_legal;
	logic                       store_hit;
	logic                       do_load;
	logic                       do_erase;
	logic                       do_write;
	logic                       buf_clear;
	logic                       busy_done;
	logic [WIDX_W-1:0]          load_idx;
	logic [31:0]                rd_word;
	logic                       rd_hit;

	// ---------------- AXI4-Lite slave ----------------
	// address and data taken together, one write outstanding
	assign wr_fire       = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
	assign S_AXI_AWREADY = wr_fire;
	assign S_AXI_WREADY  = wr_fire;
	assign wr_hit        = (S_AXI_AWADDR[7:2] == fsp_pkg::OFS_CTRL[7:2])
		|| (S_AXI_AWADDR[7:2] == fsp_pkg::OFS_STATUS[7:2]);
	assign wr_ctrl       = wr_fire && S_AXI_WSTRB[0]
		&& (S_AXI_AWADDR[7:2] == fsp_pkg::OFS_CTRL[7:2]);
	assign wr_cmd        = S_AXI_WDATA[4:0];

	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= fsp_pkg::RESP_OKAY;
		end
		else if (wr_fire)
		begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP  <= wr_hit ? fsp_pkg::RESP_OKAY
				: fsp_pkg::RESP_SLVERR;
		end
		else if (S_AXI_BREADY)
		begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign rd_hit = (S_AXI_ARADDR[7:2] == fsp_pkg::OFS_CTRL[7:2])
		|| (S_AXI_ARADDR[7:2] == fsp_pkg::OFS_STATUS[7:2]);

	always_comb
	begin
		rd_word = 32'h0000_0000;
		if (S_AXI_ARADDR[7:2] == fsp_pkg::OFS_CTRL[7:2])
		begin
			rd_word[4:0] = ctrl_ff;
		end
		else if (S_AXI_ARADDR[7:2] == fsp_pkg::OFS_STATUS[7:2])
		begin
			rd_word[fsp_pkg::SB_BUSY]  = (state_ff == FSP_ERASE)
				|| (state_ff == FSP_STREAM) || (state_ff == FSP_PROGRAM);
			rd_word[fsp_pkg::SB_ARMED] = (state_ff == FSP_ARMED);
			rd_word[fsp_pkg::SB_HALT]  = CPU_HALT;
		end
	end

	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h0000_0000;
			S_AXI_RRESP  <= fsp_pkg::RESP_OKAY;
		end
		else if (S_AXI_ARVALID && !S_AXI_RVALID)
		begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA  <= rd_word;
			S_AXI_RRESP  <= rd_hit ? fsp_pkg::RESP_OKAY
				: fsp_pkg::RESP_SLVERR;
		end
		else if (S_AXI_RREADY)
		begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	// ---------------- command arming ----------------
	// commands are only accepted while no operation is running
	assign cmd_legal = (wr_cmd == fsp_pkg::CMD_LOCKRD)
		|| (wr_cmd == fsp_pkg::CMD_SECTRD)
		|| (wr_cmd == fsp_pkg::CMD_WRITE)
		|| (wr_cmd == fsp_pkg::CMD_ERASE)
		|| (wr_cmd == fsp_pkg::CMD_LOAD);

	// the instruction is honoured wherever it is fetched from
	assign store_hit = (state_ff == FSP_ARMED) && STORE_INSTR;
	assign do_load   = store_hit && (ctrl_ff == fsp_pkg::CMD_LOAD);
	assign do_erase  = store_hit && (ctrl_ff == fsp_pkg::CMD_ERASE);
	assign do_write  = store_hit && (ctrl_ff == fsp_pkg::CMD_WRITE);
	assign busy_done = (busy_cnt_ff == 20'h00000);

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			FSP_IDLE:
			begin
				if (wr_ctrl && cmd_legal)
				begin
					nxt_state = FSP_ARMED;
				end
			end
			FSP_ARMED:
			begin
				if (do_erase)
				begin
					nxt_state = FSP_ERASE;
				end
				else if (do_write)
				begin
					nxt_state = FSP_STREAM;
				end
				else if (store_hit || (win_ff == fsp_pkg::ARM_WINDOW))
				begin
					nxt_state = FSP_IDLE;
				end
			end
			FSP_ERASE:
			begin
				if (busy_done)
				begin
					nxt_state = FSP_IDLE;
				end
			end
			FSP_STREAM:
			begin
				if (stream_vld_ff && (stream_idx_ff == WIDX_W'(31)))
				begin
					nxt_state = FSP_PROGRAM;
				end
			end
			FSP_PROGRAM:
			begin
				if (busy_done)
				begin
					nxt_state = FSP_IDLE;
				end
			end
			default:
			begin
				nxt_state = FSP_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			state_ff <= FSP_IDLE;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	// control bits stay set through erase and write, clear on return
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			ctrl_ff <= fsp_pkg::CTRL_RESET;
		end
		else if ((state_ff == FSP_IDLE) && wr_ctrl && cmd_legal)
		begin
			ctrl_ff <= wr_cmd;
		end
		else if (nxt_state == FSP_IDLE)
		begin
			ctrl_ff <= fsp_pkg::CTRL_RESET;
		end
	end

	// cycles since the arming write; store accepted on counts 1..4
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			win_ff <= 3'h0;
		end
		else if (state_ff != FSP_ARMED)
		begin
			win_ff <= 3'h1;
		end
		else
		begin
			win_ff <= win_ff + 3'h1;
		end
	end

	// ---------------- operation timing ----------------
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			busy_cnt_ff <= 20'h00000;
		end
		else if (do_erase)
		begin
			busy_cnt_ff <= 20'(ERASE_CYCLES - 1);
		end
		else if (nxt_state == FSP_PROGRAM && state_ff == FSP_STREAM)
		begin
			busy_cnt_ff <= 20'(WRITE_CYCLES - 1);
		end
		else if (!busy_done)
		begin
			busy_cnt_ff <= busy_cnt_ff - 20'h00001;
		end
	end

	// page captured for erase and write; word and data pair ignored
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			page_ff <= '0;
		end
		else if (do_erase || do_write)
		begin
			page_ff <= FLASH_PTR[fsp_pkg::PTR_BITS-1:fsp_pkg::PAGE_LSB];
		end
	end

	// halt held from the store until the timed operation ends
	assign CPU_HALT = (state_ff == FSP_ERASE) || (state_ff == FSP_STREAM)
		|| (state_ff == FSP_PROGRAM);

	// ---------------- page buffer ----------------
	assign load_idx = FLASH_PTR[fsp_pkg::WORD_LSB+WIDX_W-1:fsp_pkg::WORD_LSB];
	assign buf_clear = (state_ff == FSP_PROGRAM && busy_done)
		|| (wr_ctrl && cmd_legal && wr_cmd[fsp_pkg::CB_SRE]
		&& state_ff == FSP_IDLE)
		|| EEPROM_WRITE;

	// write side reads the buffer one word a cycle, data one cycle later
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			idx_ff        <= '0;
			stream_vld_ff <= 1'b0;
			stream_idx_ff <= '0;
		end
		else
		begin
			stream_vld_ff <= (state_ff == FSP_STREAM)
				&& !(stream_vld_ff && stream_idx_ff == WIDX_W'(31))
				&& !(idx_ff == '0 && stream_vld_ff);
			stream_idx_ff <= idx_ff;
			if (state_ff == FSP_STREAM && !(idx_ff == WIDX_W'(31)))
			begin
				idx_ff <= idx_ff + WIDX_W'(1);
			end
			else if (state_ff != FSP_STREAM)
			begin
				idx_ff <= '0;
			end
		end
	end

	// one valid bit per buffer word; loads in any order, cleared as a whole
	genvar gi;
	generate
		for (gi = 0; gi < fsp_pkg::PAGE_WORDS; gi++)
		begin : g_valid
			always_ff @(posedge REF_CLK or negedge ARST_N)
			begin
				if (!ARST_N)
				begin
					valid_ff[gi] <= 1'b0;
				end
				else if (do_load && load_idx == WIDX_W'(gi))
				begin
					valid_ff[gi] <= 1'b1;
				end
				else if (buf_clear)
				begin
					valid_ff[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	fsp_page_mem u_mem
	(
		.clk   (REF_CLK),
		.we    (do_load),
		.waddr (load_idx),
		.wdata (DATA_PAIR),
		.raddr (idx_ff),
		.rdata (mem_rdata)
	);

	// ---------------- flash array side ----------------
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			FLASH_ERASE <= 1'b0;
			FLASH_PROG  <= 1'b0;
			FLASH_PAGE  <= '0;
			FLASH_WIDX  <= '0;
			FLASH_WDATA <= fsp_pkg::ERASED_WORD;
		end
		else
		begin
			FLASH_ERASE <= do_erase;
			FLASH_PROG  <= stream_vld_ff;
			FLASH_PAGE  <= (do_erase || do_write)
				? FLASH_PTR[fsp_pkg::PTR_BITS-1:fsp_pkg::PAGE_LSB] : page_ff;
			FLASH_WIDX  <= stream_idx_ff;
			FLASH_WDATA <= valid_ff[stream_idx_ff] ? mem_rdata
				: fsp_pkg::ERASED_WORD;
		end
	end
endmodule
`default_nettype wire

// ===== logic/fsp_pkg.sv
// Purpose: shared constants for the flash self-programming sequencer
// Assumes: 25 MHz system clock, 16-bit flash words, 32-word pages
// Notes:   byte offsets are for the AXI4-Lite register window
`default_nettype none
package fsp_pkg;
	localparam int          CLK_HZ        = 25000000;
	localparam int          PAGE_WORDS    = 32;
	localparam int          WIDX_BITS     = 5;
	localparam int          WORD_BITS     = 16;
	localparam int          PTR_BITS      = 16;
	localparam int          PAGE_BITS     = 10;
	// pointer layout: bit 0 byte select, 5:1 word in page, 15:6 page index
	localparam int          WORD_LSB      = 1;
	localparam int          PAGE_LSB      = 6;
	// register byte offsets
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_STATUS    = 8'h04;
	// control register field positions
	localparam int          CB_SPE        = 0;
	localparam int          CB_ERS        = 1;
	localparam int          CB_WRT        = 2;
	localparam int          CB_BLB        = 3;
	localparam int          CB_SRE        = 4;
	// accepted lower five-bit control combinations, then the reset value
	localparam logic [4:0]  CMD_LOCKRD    = 5'h09;
	localparam logic [4:0]  CMD_SECTRD    = 5'h11;
	localparam logic [4:0]  CMD_WRITE     = 5'h05;
	localparam logic [4:0]  CMD_ERASE     = 5'h03;
	localparam logic [4:0]  CMD_LOAD      = 5'h01;
	localparam logic [4:0]  CTRL_RESET    = 5'h00;
	// status register field positions
	localparam int          SB_BUSY       = 0;
	localparam int          SB_ARMED      = 1;
	localparam int          SB_HALT       = 2;
	// store instruction must follow within this many cycles
	localparam logic [2:0]  ARM_WINDOW    = 3'h4;
	// operation times, microseconds, and derived cycle counts
	localparam int          ERASE_TIME_US = 4000;
	localparam int          WRITE_TIME_US = 4000;
	localparam int          ERASE_CYC     = ERASE_TIME_US * (CLK_HZ / 1000000);
	localparam int          WRITE_CYC     = WRITE_TIME_US * (CLK_HZ / 1000000);
	localparam logic [15:0] ERASED_WORD   = 16'hFFFF;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage
`default_nettype wire

// ===== logic/fsp_page_mem.sv
// Purpose: temporary page buffer storage, one write and one read port
// Assumes: read data registered, one cycle after the address
// Notes:   word validity is tracked by the sequencer, not here
`timescale 1ns/10ps
`default_nettype none
module fsp_page_mem
(
	input  wire logic                          clk,
	input  wire logic                          we,
	input  wire logic [fsp_pkg::WIDX_BITS-1:0] waddr,
	input  wire logic [fsp_pkg::WORD_BITS-1:0] wdata,
	input  wire logic [fsp_pkg::WIDX_BITS-1:0] raddr,
	output var  logic [fsp_pkg::WORD_BITS-1:0] rdata
);
	logic [fsp_pkg::WORD_BITS-1:0] mem [fsp_pkg::PAGE_WORDS];

	always_ff @(posedge clk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk)
	begin
		rdata <= mem[raddr];
	end
endmodule
`default_nettype wire

// ===== verification/fsp_asserts.sv
// Purpose: port checks on the flash self-programming sequencer
// Assumes: halt lengths are counted in REF_CLK cycles
// Notes:   bound to every sequencer instance
`timescale 1ns/10ps
`default_nettype none
module fsp_asserts
#(
	parameter int ERASE_CYCLES = 20,
	parameter int WRITE_CYCLES = 20
)
(
	input wire logic       REF_CLK,
	input wire logic       ARST_N,
	input wire logic       STORE_INSTR,
	input wire logic       CPU_HALT,
	input wire logic       FLASH_ERASE,
	input wire logic       FLASH_PROG,
	input wire logic [4:0] FLASH_WIDX
);
	logic [31:0] halt_cnt_ff;
	logic        ers_ff;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);
	always_ff @(posedge REF_CLK or negedge ARST_N)
		if (!ARST_N)
			halt_cnt_ff <= 32'h0;
		else
			halt_cnt_ff <= CPU_HALT ? halt_cnt_ff + 32'h1 : 32'h0;
	// remembers which operation owns the current halt
	always_ff @(posedge REF_CLK or negedge ARST_N)
		if (!ARST_N)
			ers_ff <= 1'b0;
		else if (FLASH_ERASE | FLASH_PROG)
			ers_ff <= FLASH_ERASE;
	erase_cause_a: assert property (
		FLASH_ERASE |-> $past(STORE_INSTR))
		else $error("erase without a store");
	erase_halt_a: assert property (
		FLASH_ERASE |-> CPU_HALT ##1 !FLASH_ERASE)
		else $error("erase pulse or halt wrong");
	erase_len_a: assert property (
		$fell(CPU_HALT) && ers_ff |-> halt_cnt_ff == 32'(ERASE_CYCLES))
		else $error("erase halt length wrong");
	write_len_a: assert property (
		$fell(CPU_HALT) && !ers_ff |-> halt_cnt_ff == 32'(WRITE_CYCLES + 33))
		else $error("write halt length wrong");
	prog_halt_a: assert property (
		FLASH_PROG |-> CPU_HALT)
		else $error("programming without halt");
	prog_step_a: assert property (
		FLASH_PROG && FLASH_WIDX != 5'h1F |=>
		FLASH_PROG && FLASH_WIDX == $past(FLASH_WIDX) + 5'h01)
		else $error("word sweep broken");
	prog_first_a: assert property (
		$rose(FLASH_PROG) |-> FLASH_WIDX == 5'h00 && $past(CPU_HALT))
		else $error("word sweep start wrong");
	halt_cause_a: assert property (
		$rose(CPU_HALT) |-> $past(STORE_INSTR))
		else $error("halt without a store");
endmodule
bind fsp_sequencer fsp_asserts #(
	.ERASE_CYCLES(ERASE_CYCLES),
	.WRITE_CYCLES(WRITE_CYCLES)
) chk_i (.REF_CLK, .ARST_N, .STORE_INSTR, .CPU_HALT, .FLASH_ERASE,
	.FLASH_PROG, .FLASH_WIDX);
`default_nettype wire

// ===== verification/fsp_core_model.sv
// Purpose: processor core issuing store-program instructions
// Assumes: one store per call, never while halted
// Notes:   operands wander between stores
`timescale 1ns/10ps
`default_nettype none
module fsp_core_model
(
	input  wire logic        clk,
	input  wire logic        halt,
	output var  logic        store,
	output var  logic [15:0] ptr,
	output var  logic [15:0] data
);
	initial
	begin
		store = 1'b0;
		ptr = 16'h0;
		data = 16'h0;
	end
	// operands are meaningless outside a store
	always @(negedge clk)
		if (!store)
		begin
			ptr <= ~ptr;
			data <= data + 16'h1357;
		end
	task automatic op(input logic [15:0] p, input logic [15:0] d);
		while (halt)
			@(posedge clk);
		store <= 1'b1;
		ptr <= p;
		data <= d;
		@(posedge clk);
		store <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Purpose: self-checking bench for the sequencer
// Assumes: short erase and write counts
// Notes:   programmed words are scored against a buffer model
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  awa = 8'h00;
	logic [7:0]  ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic        awv = 1'b0;
	logic        wv = 1'b0;
	logic        brdy = 1'b0;
	logic        arv = 1'b0;
	logic        rrdy = 1'b0;
	logic        eew = 1'b0;
	logic        awr, wr, bv, arr, rv, st, halt, ers, prg;
	logic [1:0]  br, rr;
	logic [31:0] rd;
	logic [15:0] ptr, dp, fwd;
	logic [9:0]  pg;
	logic [4:0]  wi;
	logic [15:0] buf_m [32];
	logic [31:0] q [$];
	logic [4:0]  bad [5] = '{5'h02, 5'h07, 5'h1F, 5'h13, 5'h0D};
	int          errors = 0;
	int          n_checks = 0;
	always #20 clk = ~clk;
	fsp_sequencer #(.ERASE_CYCLES(20), .WRITE_CYCLES(20)) dut (
		.REF_CLK(clk), .ARST_N(rst_n), .S_AXI_AWADDR(awa),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
		.S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
		.S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
		.S_AXI_RREADY(rrdy), .STORE_INSTR(st), .FLASH_PTR(ptr),
		.DATA_PAIR(dp), .EEPROM_WRITE(eew), .CPU_HALT(halt),
		.FLASH_ERASE(ers), .FLASH_PROG(prg), .FLASH_PAGE(pg),
		.FLASH_WIDX(wi), .FLASH_WDATA(fwd));
	fsp_core_model core (.clk(clk), .halt(halt), .store(st),
		.ptr(ptr), .data(dp));
	task automatic end_of_test();
		if (errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		do @(posedge clk); while (!awr);
		awv <= 1'b0;
		wv <= 1'b0;
		do @(posedge clk); while (!bv);
		brdy <= 1'b0;
		chk({30'h0, br}, 32'h0);
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		do @(posedge clk); while (!arr);
		arv <= 1'b0;
		do @(posedge clk); while (!rv);
		rrdy <= 1'b0;
		chk(rd, d);
		chk({30'h0, rr}, {30'h0, e});
	endtask
	task automatic load(input logic [4:0] i, input logic [15:0] d);
		axw(8'h00, {$urandom} & 32'hFFFF_FFE0 | 32'h01);
		buf_m[i] = d;
		core.op({10'($urandom), i, 1'($urandom)}, d);
	endtask
	task automatic wait_idle();
		do @(posedge clk); while (halt);
	endtask
	task automatic erase(input logic [9:0] p);
		q.push_back({1'b1, p, 21'h0});
		axw(8'h00, 32'h03);
		core.op({p, 6'($urandom)}, 16'($urandom));
		axr(8'h04, 32'h5, 2'h0);
		wait_idle();
	endtask
	task automatic prog(input logic [9:0] p);
		foreach (buf_m[i])
		begin
			q.push_back({1'b0, p, 5'(i), buf_m[i]});
			buf_m[i] = 16'hFFFF;
		end
		axw(8'h00, 32'h05);
		core.op({p, 6'h0}, 16'h0);
		axr(8'h04, 32'h5, 2'h0);
		wait_idle();
	endtask
	always @(posedge clk)
		if (ers | prg)
			chk({ers, pg, prg ? wi : 5'h0, prg ? fwd : 16'h0},
				q.size() ? q.pop_front() : 'x);
	initial
	begin
		#400000;
		errors++;
		end_of_test();
	end
	initial
	begin
		void'($urandom(74));
		foreach (buf_m[i])
			buf_m[i] = 16'hFFFF;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		axr(8'h00, 32'h0, 2'h0);
		axr(8'h04, 32'h0, 2'h0);
		axr(8'h0C, 32'h0, 2'h2);
		for (int k = 0; k < 20; k++)
			load(5'(k * 13 + 5), 16'($urandom));
		erase(10'h2A5);
		prog(10'h2A5);
		erase(10'h0C3);
		load(5'h1F, 16'($urandom));
		load(5'h00, 16'($urandom));
		prog(10'h0C3);
		foreach (bad[i])
		begin
			axw(8'h00, {27'($urandom), bad[i]});
			axr(8'h00, 32'h0, 2'h0);
		end
		axw(8'h00, 32'h09);
		axr(8'h00, 32'h09, 2'h0);
		load(5'h03, 16'h1234);
		axw(8'h00, 32'h11);
		buf_m[3] = 16'hFFFF;
		axr(8'h04, 32'h2, 2'h0);
		load(5'h07, 16'h5678);
		eew <= 1'b1;
		@(posedge clk);
		eew <= 1'b0;
		buf_m[7] = 16'hFFFF;
		axw(8'h00, 32'h01);
		repeat (4) @(posedge clk);
		core.op(16'h0012, 16'hABCD);
		axr(8'h00, 32'h0, 2'h0);
		prog(10'h011);
		load(5'h04, 16'h4444);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		buf_m[4] = 16'hFFFF;
		prog(10'h3FF);
		chk(q.size(), 32'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
